// ===== verilog/uart_auto_flow.sv
`timescale 1ns/100ps
`include "flow_params.svh"
// Overview of operation
// - Auto CTS on: transmitter halts while CTS input high, resumes when low.
// - Auto RTS on: interrupt when receive level reaches programmed trigger.
// - Auto RTS on: RTS output goes high at the next higher level.
// - Auto RTS: RTS returns low once level drops below the lower level.
// - Auto RTS off: RTS output follows the software modem control bit.
// - Auto RTS, special detect and enhanced enable bits reset to zero.
// - Special detect: compare each character to stop char; still store it.
// - A match sets interrupt status bit 4.
// - Stop character bit 0 compares with received character LSB.
// - Guarded enable, status, FIFO, modem bits writable only when enhanced.
// - Clearing enhanced bit freezes guarded bits until it is set again.
// - Auto CTS enable resets to zero, so CTS gating starts disabled.
module uart_auto_flow (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic CTS_N,
    input wire logic [7:0] RX_LEVEL,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_CHAR,
    output logic RTS_N,
    output logic TX_HALT,
    output logic RX_PUSH,
    output logic [7:0] RX_PUSH_DATA,
    output logic IRQ
);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    flow_pkg::bus_phase_e phase_r;
    flow_pkg::bus_phase_e phase_nxt;
    logic [7:0] wr_addr_r;
    logic [31:0] rdata_r;
    logic ready_r;
    logic resp_r;

    wire addr_take = HSEL & HREADY & HTRANS[1];
    wire [7:0] addr_lo = HADDR[7:0];

    assign phase_nxt = !addr_take ? flow_pkg::PH_IDLE :
                       HWRITE ? flow_pkg::PH_WRITE : flow_pkg::PH_READ;

    wire wr_en = (phase_r == flow_pkg::PH_WRITE);
    wire rd_take = addr_take & ~HWRITE;
    wire [7:0] wbyte = HWDATA[7:0];

    always_ff @(posedge CLK) begin
        if (SRST) begin
            phase_r <= flow_pkg::PH_IDLE;
            wr_addr_r <= `BYTE_RST;
            ready_r <= 1'b1;
            resp_r <= `AHB_OKAY;
        end else begin
            phase_r <= phase_nxt;
            wr_addr_r <= addr_take ? addr_lo : wr_addr_r;
            ready_r <= 1'b1;
            resp_r <= `AHB_OKAY;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    flow_pkg::byte_t feat_r;
    flow_pkg::byte_t ien_r;
    flow_pkg::byte_t stat_r;
    flow_pkg::byte_t fifo_r;
    flow_pkg::byte_t modem_r;
    flow_pkg::byte_t stop_r;
    logic [23:0] trig_r;

    wire sel_feat = wr_en & (wr_addr_r == `FEAT_OFS);
    wire sel_ien = wr_en & (wr_addr_r == `IEN_OFS);
    wire sel_stat = wr_en & (wr_addr_r == `STAT_OFS);
    wire sel_fifo = wr_en & (wr_addr_r == `FIFO_OFS);
    wire sel_trig = wr_en & (wr_addr_r == `TRIG_OFS);
    wire sel_modem = wr_en & (wr_addr_r == `MODEM_OFS);
    wire sel_stop = wr_en & (wr_addr_r == `STOP_OFS);

    wire enh = feat_r[`FEAT_ENH];

    // Guarded bits keep their latched value unless enhanced mode is on
    wire [7:0] ien_wr = (wbyte & ~`IEN_PROT) |
                        ((enh ? wbyte : ien_r) & `IEN_PROT);
    wire [7:0] fifo_wr = (wbyte & ~`FIFO_PROT) |
                         ((enh ? wbyte : fifo_r) & `FIFO_PROT);
    wire [7:0] modem_wr = (wbyte & ~`MODEM_PROT) |
                          ((enh ? wbyte : modem_r) & `MODEM_PROT);

    // Status clears are write-one; guarded bits clear only when enhanced
    wire [7:0] stat_clr = sel_stat ?
                          (wbyte & (enh ? 8'hff : ~`STAT_PROT)) : 8'h00;

    // ------------------------------------------------------------
    // Events and status
    // ------------------------------------------------------------
    flow_if ifc ();

    logic cts_d_r;
    logic halt_r;
    logic irq_r;
    logic [7:0] stat_evt;

    assign stat_evt[`STAT_TRIG] = ifc.trig_evt;
    assign stat_evt[`STAT_CTS] = feat_r[`FEAT_AUTO_CTS] & (CTS_N ^ cts_d_r);
    assign stat_evt[3:2] = 2'b00;
    assign stat_evt[`STAT_SPEC] = ifc.match_evt;
    assign stat_evt[7:5] = 3'b000;

    // A new event in the clearing cycle survives the clear
    wire [7:0] stat_nxt = (stat_r & ~stat_clr) | stat_evt;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            feat_r <= `BYTE_RST;
            ien_r <= `BYTE_RST;
            stat_r <= `BYTE_RST;
            fifo_r <= `BYTE_RST;
            modem_r <= `BYTE_RST;
            stop_r <= `BYTE_RST;
            trig_r <= `TRIG_RST;
        end else begin
            feat_r <= sel_feat ? wbyte : feat_r;
            ien_r <= sel_ien ? ien_wr : ien_r;
            stat_r <= stat_nxt;
            fifo_r <= sel_fifo ? fifo_wr : fifo_r;
            modem_r <= sel_modem ? modem_wr : modem_r;
            stop_r <= sel_stop ? wbyte : stop_r;
            trig_r <= sel_trig ? HWDATA[23:0] : trig_r;
        end
    end

    // ------------------------------------------------------------
    // Transmit gating and interrupt
    // ------------------------------------------------------------
    // CTS is taken as synchronous; halt lags the pin by one cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            cts_d_r <= 1'b1;
            halt_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            cts_d_r <= CTS_N;
            halt_r <= feat_r[`FEAT_AUTO_CTS] & CTS_N;
            irq_r <= |(stat_r & ien_r);
        end
    end

    // ------------------------------------------------------------
    // Flow units
    // ------------------------------------------------------------
    assign ifc.auto_rts_en = feat_r[`FEAT_AUTO_RTS];
    assign ifc.spec_en = feat_r[`FEAT_SPEC_DET];
    assign ifc.sw_rts = modem_r[`MODEM_RTS];
    assign ifc.trig_lvl = trig_r[7:0];
    assign ifc.hi_lvl = trig_r[15:8];
    assign ifc.lo_lvl = trig_r[23:16];
    assign ifc.stop_char = stop_r;

    rts_hysteresis u_rts (
        .clk(CLK),
        .srst(SRST),
        .rx_level(RX_LEVEL),
        .link(ifc)
    );

    stop_char_match u_match (
        .clk(CLK),
        .srst(SRST),
        .rx_valid(RX_VALID),
        .rx_char(RX_CHAR),
        .push(RX_PUSH),
        .push_data(RX_PUSH_DATA),
        .link(ifc)
    );

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [7:0] line_bits = {5'h00, halt_r, ifc.rts_n, CTS_N};
    wire [31:0] rd_word =
        (addr_lo == `FEAT_OFS) ? {24'h000000, feat_r} :
        (addr_lo == `IEN_OFS) ? {24'h000000, ien_r} :
        (addr_lo == `STAT_OFS) ? {24'h000000, stat_r} :
        (addr_lo == `FIFO_OFS) ? {24'h000000, fifo_r} :
        (addr_lo == `TRIG_OFS) ? {8'h00, trig_r} :
        (addr_lo == `MODEM_OFS) ? {24'h000000, modem_r} :
        (addr_lo == `STOP_OFS) ? {24'h000000, stop_r} :
        (addr_lo == `LINE_OFS) ? {16'h0000, RX_LEVEL, line_bits} :
        32'h00000000;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata_r <= 32'h00000000;
        end else begin
            rdata_r <= rd_take ? rd_word : rdata_r;
        end
    end

    assign HRDATA = rdata_r;
    assign HREADYOUT = ready_r;
    assign HRESP = resp_r;
    assign RTS_N = ifc.rts_n;
    assign TX_HALT = halt_r;
    assign IRQ = irq_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    sequence s_wr_addr(logic [7:0] ofs);
        addr_take && HWRITE && addr_lo == ofs;
    endsequence

    sequence s_locked;
        !enh;
    endsequence

    a_tx_halt_cts: assert property (
        feat_r[`FEAT_AUTO_CTS] && CTS_N |=> halt_r)
        else $error("transmitter not halted on CTS high");
    a_tx_resume: assert property (
        $fell(CTS_N) |=> !halt_r)
        else $error("transmitter not resumed on CTS low");
    a_reset_zero: assert property (
        disable iff (1'b0) SRST |=> feat_r == 8'h00 && !halt_r)
        else $error("feature bits not cleared by reset");
    a_cts_rst_off: assert property (
        disable iff (1'b0) SRST ##1 !SRST && feat_r == 8'h00 |=> !halt_r)
        else $error("CTS gating active after reset");
    a_spec_status: assert property (
        ifc.match_evt |=> stat_r[`STAT_SPEC])
        else $error("special character status not set");
    a_ien_locked: assert property (
        s_wr_addr(`IEN_OFS) ##0 s_locked ##1 s_locked |=>
        ien_r[7:4] == $past(ien_r[7:4]))
        else $error("guarded enable bits changed while locked");
    a_modem_frozen: assert property (
        s_wr_addr(`MODEM_OFS) ##0 s_locked ##1 s_locked |=>
        modem_r[7:5] == $past(modem_r[7:5]))
        else $error("guarded modem bits changed while locked");
    a_ien_open: assert property (
        s_wr_addr(`IEN_OFS) ##0 enh ##1 enh |=>
        ien_r == $past(HWDATA[7:0]))
        else $error("enable write lost in enhanced mode");
    a_irq_level: assert property (
        (stat_r & ien_r) != 8'h00 |=> IRQ)
        else $error("interrupt not raised");
    a_irq_quiet: assert property (
        (stat_r & ien_r) == 8'h00 |=> !IRQ)
        else $error("interrupt raised with nothing pending");
    a_trig_status: assert property (
        ifc.trig_evt |=> stat_r[`STAT_TRIG])
        else $error("trigger status not set");
    a_trig_quiet: assert property (
        !ifc.auto_rts_en |=> !ifc.trig_evt)
        else $error("trigger event without auto RTS");
    a_cts_status: assert property (
        feat_r[`FEAT_AUTO_CTS] && $changed(CTS_N) |=> stat_r[`STAT_CTS])
        else $error("CTS change status not set");
    a_halt_manual: assert property (
        !feat_r[`FEAT_AUTO_CTS] |=> !halt_r)
        else $error("transmitter halted without auto CTS");

    // ------------------------------------------------------------
    // Guarded-bit checks
    // ------------------------------------------------------------
    // The enhanced bit is read in the data phase, before any write lands
    a_fifo_locked: assert property (
        s_wr_addr(`FIFO_OFS) ##0 s_locked ##1 s_locked |=>
        fifo_r[5:4] == $past(fifo_r[5:4]))
        else $error("guarded FIFO bits changed while locked");
    a_fifo_open: assert property (
        s_wr_addr(`FIFO_OFS) ##0 enh ##1 enh |=>
        fifo_r == $past(HWDATA[7:0]))
        else $error("FIFO write lost in enhanced mode");
    a_modem_open: assert property (
        s_wr_addr(`MODEM_OFS) ##0 enh ##1 enh |=>
        modem_r == $past(HWDATA[7:0]))
        else $error("modem write lost in enhanced mode");
    // A locked status bit also ignores its write-one clear
    a_stat_frozen: assert property (
        s_locked ##0 stat_r[`STAT_SPEC] |=> stat_r[`STAT_SPEC])
        else $error("guarded status bit cleared while locked");
    a_stat_clear: assert property (
        sel_stat && enh && wbyte[`STAT_SPEC] && !ifc.match_evt |=>
        !stat_r[`STAT_SPEC])
        else $error("guarded status bit not cleared when enhanced");
endmodule

// ===== verilog/flow_params.svh
`ifndef FLOW_PARAMS_SVH
`define FLOW_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define FEAT_OFS 8'h00
`define IEN_OFS 8'h04
`define STAT_OFS 8'h08
`define FIFO_OFS 8'h0c
`define TRIG_OFS 8'h10
`define MODEM_OFS 8'h14
`define STOP_OFS 8'h18
`define LINE_OFS 8'h1c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FEAT_AUTO_CTS 7
`define FEAT_AUTO_RTS 6
`define FEAT_SPEC_DET 5
`define FEAT_ENH 4
`define STAT_TRIG 0
`define STAT_CTS 1
`define STAT_SPEC 4
`define MODEM_RTS 1

// ----------------------------------------------------------------
// Masks of the bits guarded by the enhanced-function bit
// ----------------------------------------------------------------
`define IEN_PROT 8'hf0
`define STAT_PROT 8'h30
`define FIFO_PROT 8'h30
`define MODEM_PROT 8'he0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BYTE_RST 8'h00
`define TRIG_RST 24'h082010
`define AHB_OKAY 1'b0

`endif

// ===== verilog/flow_pkg.sv
package flow_pkg;
    typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ} bus_phase_e;
    typedef logic [7:0] byte_t;
endpackage

// ===== verilog/flow_if.sv
`timescale 1ns/100ps
interface flow_if;
    logic auto_rts_en;
    logic spec_en;
    logic sw_rts;
    flow_pkg::byte_t trig_lvl;
    flow_pkg::byte_t hi_lvl;
    flow_pkg::byte_t lo_lvl;
    flow_pkg::byte_t stop_char;
    logic trig_evt;
    logic match_evt;
    logic rts_n;

    modport ctrl (
        output auto_rts_en, spec_en, sw_rts, trig_lvl, hi_lvl, lo_lvl,
        output stop_char,
        input trig_evt, match_evt, rts_n
    );
    modport rts_unit (
        input auto_rts_en, sw_rts, trig_lvl, hi_lvl, lo_lvl,
        output trig_evt, rts_n
    );
    modport match_unit (
        input spec_en, stop_char,
        output match_evt
    );
endinterface

// ===== verilog/rts_hysteresis.sv
`timescale 1ns/100ps
`include "flow_params.svh"
module rts_hysteresis (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] rx_level,
    flow_if.rts_unit link
);
    logic stop_r;
    logic reached_r;
    logic trig_r;
    logic rts_n_r;

    wire reached = rx_level >= link.trig_lvl;
    wire go_stop = rx_level >= link.hi_lvl;
    wire go_run = rx_level < link.lo_lvl;
    // Between the two levels the last decision holds
    wire stop_nxt = !link.auto_rts_en ? 1'b0 :
                    go_stop ? 1'b1 :
                    go_run ? 1'b0 : stop_r;
    // Pin is active low: high asks the far end to stop
    wire rts_nxt = link.auto_rts_en ? stop_nxt : ~link.sw_rts;

    always_ff @(posedge clk) begin
        if (srst) begin
            stop_r <= 1'b0;
            reached_r <= 1'b0;
            trig_r <= 1'b0;
            rts_n_r <= 1'b1;
        end else begin
            stop_r <= stop_nxt;
            reached_r <= reached;
            trig_r <= link.auto_rts_en & reached & ~reached_r;
            rts_n_r <= rts_nxt;
        end
    end

    assign link.trig_evt = trig_r;
    assign link.rts_n = rts_n_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_rts_stop_high: assert property (
        link.auto_rts_en && go_stop |=> rts_n_r)
        else $error("rts not high at upper level");
    a_rts_run_low: assert property (
        link.auto_rts_en && go_run && !go_stop |=> !rts_n_r)
        else $error("rts not low below lower level");
    a_rts_manual: assert property (
        !link.auto_rts_en |=> rts_n_r == !$past(link.sw_rts))
        else $error("rts does not follow software setting");
    a_trig_event: assert property (
        link.auto_rts_en && reached && !reached_r |=> trig_r ##1 !trig_r)
        else $error("trigger interrupt event missing");
endmodule

// ===== verilog/stop_char_match.sv
`timescale 1ns/100ps
`include "flow_params.svh"
module stop_char_match (
    input wire logic clk,
    input wire logic srst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    output logic push,
    output logic [7:0] push_data,
    flow_if.match_unit link
);
    logic [7:0] bit_eq;
    logic push_r;
    logic match_r;
    flow_pkg::byte_t data_r;

    // Bit 0 of the stop character meets the first-received LSB
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            assign bit_eq[i] = ~(rx_char[i] ^ link.stop_char[i]);
        end
    endgenerate

    wire hit = rx_valid & link.spec_en & (&bit_eq);

    always_ff @(posedge clk) begin
        if (srst) begin
            push_r <= 1'b0;
            match_r <= 1'b0;
            data_r <= `BYTE_RST;
        end else begin
            push_r <= rx_valid;
            match_r <= hit;
            data_r <= rx_valid ? rx_char : data_r;
        end
    end

    assign push = push_r;
    assign push_data = data_r;
    assign link.match_evt = match_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_match_still_push: assert property (
        rx_valid |=> push_r && data_r == $past(rx_char))
        else $error("received character not forwarded");
    a_match_flag: assert property (
        rx_valid && link.spec_en && rx_char == link.stop_char |=> match_r)
        else $error("stop character match not flagged");
    a_match_lsb: assert property (
        match_r |-> data_r[0] == $past(link.stop_char[0]))
        else $error("bit 0 compare misaligned");
endmodule

// ===== verification/remote_serial.sv
`timescale 1ns/100ps
// ------------------------------------------------
// Remote end of the handshake lines
// ------------------------------------------------
module remote_serial (
    input wire logic clk,
    input wire logic rts_n,
    output logic cts_n,
    output logic rx_valid,
    output logic [7:0] rx_char
);
    initial begin
        cts_n = 1'b0;
        rx_valid = 1'b0;
        rx_char = 8'h00;
    end

    task automatic set_cts(input logic lvl);
        @(posedge clk);
        cts_n <= lvl;
    endtask

    // Call just after a rising edge; returns at the edge that takes it
    task automatic send(input logic [7:0] ch, input int gap,
        output bit stuck);
        int k;
        repeat (gap) @(posedge clk);
        k = 0;
        // Holds off while the device asks it to stop
        while (rts_n === 1'b1 && k < 40) begin
            @(posedge clk);
            k++;
        end
        // A line held at stop past the bound is reported by the caller
        stuck = (k >= 40);
        if (stuck) begin
            return;
        end
        rx_valid <= 1'b1;
        rx_char <= ch;
        @(posedge clk);
        rx_valid <= 1'b0;
        // Stale data is not left on the lines
        rx_char <= ~ch;
    endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/100ps
`include "flow_params.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench;
    localparam logic [23:0] TRG = `TRIG_RST;
    logic CLK = 1'b0;
    logic SRST = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'b00;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic [7:0] RX_LEVEL = 8'h00;
    logic [31:0] HRDATA;
    logic HREADYOUT, HRESP, CTS_N, RX_VALID, RTS_N, TX_HALT, RX_PUSH, IRQ;
    logic [7:0] RX_CHAR, RX_PUSH_DATA;
    int n_errors = 0;
    int n_tests = 0;
    logic [31:0] v;
    logic [7:0] c;
    logic exp;
    logic [7:0] ga [3] = '{`IEN_OFS, `FIFO_OFS, `MODEM_OFS};
    logic [7:0] gm [3] = '{`IEN_PROT, `FIFO_PROT, `MODEM_PROT};
    logic [7:0] lv [8] = '{8'h1f, 8'h20, 8'h09, 8'h08, 8'h07, 8'h20,
        8'h21, 8'h00};

    always #25 CLK = ~CLK;

    uart_auto_flow uart_auto_flow_i (.CLK(CLK), .SRST(SRST), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'b010),
        .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CTS_N(CTS_N),
        .RX_LEVEL(RX_LEVEL), .RX_VALID(RX_VALID), .RX_CHAR(RX_CHAR),
        .RTS_N(RTS_N), .TX_HALT(TX_HALT), .RX_PUSH(RX_PUSH),
        .RX_PUSH_DATA(RX_PUSH_DATA), .IRQ(IRQ));
    remote_serial remote_serial_i (.clk(CLK), .rts_n(RTS_N), .cts_n(CTS_N),
        .rx_valid(RX_VALID), .rx_char(RX_CHAR));

    // ------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------
    task automatic give_verdict();
        if (n_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge CLK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        for (int p = 0; p < 2; p++) begin
            k = 0;
            do begin
                @(posedge CLK);
                k++;
            end while (HREADYOUT !== 1'b1 && k < 40);
            if (k >= 40) begin
                n_errors++;
                give_verdict();
            end
            if (p == 0) begin
                HSEL <= 1'b0;
                HTRANS <= 2'b00;
                HWDATA <= d;
            end
        end
        v = HRDATA;
        `CHK(HRESP, `AHB_OKAY)
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic send_chk(input logic [7:0] ch, input int gap);
        bit stuck;
        remote_serial_i.send(ch, gap, stuck);
        if (stuck) begin
            n_errors++;
            give_verdict();
        end
    endtask

    // Between the two levels the line keeps its last state
    function automatic logic rts_exp(input logic [7:0] l, input logic p);
        if (l >= TRG[15:8]) begin
            return 1'b1;
        end
        if (l < TRG[23:16]) begin
            return 1'b0;
        end
        return p;
    endfunction

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        v = $urandom(29);
        repeat (5) @(posedge CLK);
        SRST <= 1'b0;
        settle(1);
        `CHK({RTS_N, TX_HALT, RX_PUSH, IRQ}, 4'b1000)
        rd(`FEAT_OFS);
        `CHK(v, 32'h0)
        rd(`TRIG_OFS);
        `CHK(v, {8'h0, TRG})
        rd(8'h20);
        `CHK(v, 32'h0)
        rd(`LINE_OFS);
        `CHK(v, 32'h00000002)
        wr(`MODEM_OFS, 8'h02);
        settle(2);
        `CHK(RTS_N, 1'b0)
        wr(`MODEM_OFS, 8'h00);
        settle(2);
        `CHK(RTS_N, 1'b1)
        remote_serial_i.set_cts(1'b1);
        settle(3);
        `CHK(TX_HALT, 1'b0)
        wr(`FEAT_OFS, 8'h80);
        settle(2);
        `CHK(TX_HALT, 1'b1)
        remote_serial_i.set_cts(1'b0);
        settle(2);
        `CHK(TX_HALT, 1'b0)
        rd(`STAT_OFS);
        `CHK(v[`STAT_CTS], 1'b1)
        wr(`FEAT_OFS, 8'h40);
        wr(`STAT_OFS, 8'h0f);
        settle(2);
        `CHK(RTS_N, 1'b0)
        @(posedge CLK);
        RX_LEVEL <= TRG[7:0];
        settle(3);
        `CHK(IRQ, 1'b0)
        rd(`STAT_OFS);
        `CHK(v[`STAT_TRIG], 1'b1)
        wr(`IEN_OFS, 8'h01);
        settle(2);
        `CHK(IRQ, 1'b1)
        wr(`STAT_OFS, 8'h01);
        settle(2);
        `CHK(IRQ, 1'b0)
        exp = 1'b0;
        for (int i = 0; i < 30; i++) begin
            c = (i < 8) ? lv[i] : 8'($urandom_range(0, 48));
            @(posedge CLK);
            RX_LEVEL <= c;
            settle(2);
            exp = rts_exp(c, exp);
            `CHK(RTS_N, exp)
        end
        @(posedge CLK);
        RX_LEVEL <= 8'h00;
        wr(`FEAT_OFS, 8'h30);
        wr(`IEN_OFS, 8'h10);
        wr(`MODEM_OFS, 8'h02);
        wr(`STOP_OFS, 8'h01);
        wr(`STAT_OFS, 8'h3f);
        for (int i = 0; i < 12; i++) begin
            c = 8'($urandom);
            if (i == 0) begin
                c = 8'h80;
            end else if (i == 1 || $urandom_range(0, 3) == 0) begin
                c = 8'h01;
            end
            exp = (c == 8'h01);
            send_chk(c, i % 3);
            #1;
            `CHK({RX_PUSH, RX_PUSH_DATA}, {1'b1, c})
            settle(2);
            `CHK(IRQ, exp)
            rd(`STAT_OFS);
            `CHK(v[`STAT_SPEC], exp)
            wr(`STAT_OFS, 8'h10);
        end
        send_chk(8'h01, 0);
        wr(`FEAT_OFS, 8'h20);
        wr(`STAT_OFS, 8'h10);
        rd(`STAT_OFS);
        `CHK(v[`STAT_SPEC], 1'b1)
        wr(`FEAT_OFS, 8'h10);
        foreach (ga[i]) begin
            wr(ga[i], gm[i]);
        end
        wr(`FEAT_OFS, 8'h00);
        foreach (ga[i]) begin
            c = 8'($urandom);
            wr(ga[i], c);
            rd(ga[i]);
            `CHK(v, {24'h0, gm[i] | c})
        end
        wr(`FEAT_OFS, 8'h10);
        wr(`IEN_OFS, 8'h00);
        wr(`STAT_OFS, 8'h10);
        rd(`IEN_OFS);
        `CHK(v, 32'h0)
        rd(`STAT_OFS);
        `CHK(v[`STAT_SPEC], 1'b0)
        // Reset in mid-run with every feature bit set
        wr(`FEAT_OFS, 8'hf0);
        @(posedge CLK);
        SRST <= 1'b1;
        @(posedge CLK);
        SRST <= 1'b0;
        rd(`FEAT_OFS);
        `CHK(v, 32'h0)
        `CHK({RTS_N, TX_HALT}, 2'b10)
        give_verdict();
    end
endmodule
